// [include/sensor_cmd_pkg.sv]
// Constants and types for the state sensor reading command block.
// Assumes one byte-wide request and response stream per command.
package sensor_cmd_pkg;

    localparam int          MAX_SUB_SENSORS     = 8;
    localparam int          MIN_SUB_SENSORS     = 1;
    localparam int          REC_FIELDS          = 4;
    localparam logic [1:0]  REQ_LAST_BYTE       = 2'h3;
    localparam logic [1:0]  REC_LAST_FIELD      = 2'h3;
    localparam logic [3:0]  SUB_COUNT_MIN       = 4'h1;
    localparam logic [3:0]  SUB_COUNT_MAX       = 4'h8;
    localparam logic [7:0]  SUCCESS_CODE        = 8'h00;
    localparam logic [7:0]  UNKNOWN_HANDLE_CODE = 8'h80;
    localparam logic [15:0] HANDLE_RSV_LOW      = 16'h0000;
    localparam logic [15:0] HANDLE_RSV_HIGH     = 16'hFFFF;
    localparam logic [7:0]  STATE_RESET         = 8'h00;

    typedef enum logic [2:0] {
        S_REQ,
        S_CODE,
        S_COUNT,
        S_REC,
        S_DRAIN
    } ctl_state_t;

    typedef struct packed {
        ctl_state_t  st;
        logic [1:0]  byte_idx;
        logic [15:0] sensor_handle;
        logic [7:0]  rearm_mask;
        logic [3:0]  count;
        logic [2:0]  rec_idx;
        logic [1:0]  fld_idx;
        logic [7:0]  rearm;
        logic        req_ready;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic        rsp_last;
        logic        out_is_rec;
        logic [2:0]  out_rec;
        logic [1:0]  out_fld;
    } ctl_t;

    typedef struct packed {
        logic       known;
        logic       armed;
        logic [7:0] current_state;
        logic [7:0] prior_state;
        logic [7:0] last_event_state;
    } slot_t;

endpackage

// [include/sensor_slot_if.sv]
// Carrier between the command block and one sub-sensor slot.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
interface sensor_slot_if;
    logic       assess_valid;
    logic [7:0] assess_state;
    logic       rearm;
    logic [7:0] current_state;
    logic [7:0] prior_state;
    logic [7:0] last_event_state;

    modport slot (
        input  assess_valid,
        input  assess_state,
        input  rearm,
        output current_state,
        output prior_state,
        output last_event_state
    );

    modport ctl (
        output assess_valid,
        output assess_state,
        output rearm,
        input  current_state,
        input  prior_state,
        input  last_event_state
    );
endinterface

// [design/sensor_slot.sv]
// One sub-sensor: tracks current, prior and event states.
// Assumes assessed states arrive as one-cycle strobes.
`timescale 1ns/1ps
module sensor_slot
    import sensor_cmd_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    sensor_slot_if.slot  sif
);

    slot_t s;
    slot_t next_s;

    always_comb begin
        next_s = s;
        if (sif.rearm) begin
            next_s.armed = 1'b1;
        end
        if (sif.assess_valid) begin
            if (!s.known) begin
                // Prior unknown after reset, so mirror the current state
                next_s.known         = 1'b1;
                next_s.current_state = sif.assess_state;
                next_s.prior_state   = sif.assess_state;
            end else if (sif.assess_state != s.current_state) begin
                next_s.prior_state   = s.current_state;
                next_s.current_state = sif.assess_state;
            end
            if ((!s.known || sif.assess_state != s.current_state)
                    && (s.armed || sif.rearm)) begin
                next_s.last_event_state = sif.assess_state;
                next_s.armed            = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s <= '{known: 1'b0, armed: 1'b1, current_state: STATE_RESET,
                   prior_state: STATE_RESET, last_event_state: STATE_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign sif.current_state    = s.current_state;
    assign sif.prior_state      = s.prior_state;
    assign sif.last_event_state = s.last_event_state;

    property p_first_prior;
        @(posedge core_clk_i) disable iff (rst_i)
        (!s.known && sif.assess_valid)
            |=> (s.prior_state == s.current_state)
                && (s.current_state == $past(sif.assess_state));
    endproperty
    a_first_prior: assert property (p_first_prior)
        else $error("Prior state differs from current on first assessment");

endmodule

// [design/state_sensor_read_cmd.sv]
// Command block answering state sensor reading requests.
// Assumes byte streams with valid/ready; the endpoint frames messages.
`timescale 1ns/1ps
module state_sensor_read_cmd
    import sensor_cmd_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] own_handle_i,
    input  wire logic [3:0]  sub_count_i,
    input  wire logic [63:0] op_state_i,
    input  wire logic [7:0]  assess_valid_i,
    input  wire logic [63:0] assess_state_i,
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_data_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [7:0]       rsp_data_o,
    output logic             rsp_last_o,
    input  wire logic        rsp_ready_i
);

    ctl_t       s;
    ctl_t       next_s;
    logic [3:0] eff_count;
    logic [7:0] count_mask;
    logic       handle_bad;
    logic       rsp_free;
    logic [7:0] rec_byte;
    logic [7:0] cur_a   [MAX_SUB_SENSORS];
    logic [7:0] prior_a [MAX_SUB_SENSORS];
    logic [7:0] evt_a   [MAX_SUB_SENSORS];

    sensor_slot_if sif [MAX_SUB_SENSORS] ();

    genvar g;
    generate
        for (g = 0; g < MAX_SUB_SENSORS; g++) begin : gen_slot
            assign sif[g].assess_valid = assess_valid_i[g];
            assign sif[g].assess_state = assess_state_i[g*8 +: 8];
            assign sif[g].rearm        = s.rearm[g];
            assign cur_a[g]            = sif[g].current_state;
            assign prior_a[g]          = sif[g].prior_state;
            assign evt_a[g]            = sif[g].last_event_state;
            sensor_slot u_slot (
                .core_clk_i (core_clk_i),
                .rst_i      (rst_i),
                .sif        (sif[g])
            );
        end
    endgenerate

    // Out-of-range strap values clamp so the count stays legal
    always_comb begin
        if (sub_count_i < SUB_COUNT_MIN) begin
            eff_count = SUB_COUNT_MIN;
        end else if (sub_count_i > SUB_COUNT_MAX) begin
            eff_count = SUB_COUNT_MAX;
        end else begin
            eff_count = sub_count_i;
        end
        for (int i = 0; i < MAX_SUB_SENSORS; i++) begin
            count_mask[i] = (4'(i) < eff_count);
        end
    end

    assign handle_bad = (s.sensor_handle == HANDLE_RSV_LOW)
                     || (s.sensor_handle == HANDLE_RSV_HIGH)
                     || (s.sensor_handle != own_handle_i);

    assign rsp_free = !s.rsp_valid || rsp_ready_i;

    // Records read live; a mid-response assessment shows in later bytes
    always_comb begin
        case (s.fld_idx)
            2'h0:    rec_byte = op_state_i[s.rec_idx*8 +: 8];
            2'h1:    rec_byte = cur_a[s.rec_idx];
            2'h2:    rec_byte = prior_a[s.rec_idx];
            default: rec_byte = evt_a[s.rec_idx];
        endcase
    end

    always_comb begin
        next_s       = s;
        next_s.rearm = '0;
        if (s.rsp_valid && rsp_ready_i) begin
            next_s.rsp_valid = 1'b0;
            next_s.rsp_last  = 1'b0;
        end
        case (s.st)
            S_REQ: begin
                if (req_valid_i && s.req_ready) begin
                    next_s.byte_idx = s.byte_idx + 2'h1;
                    case (s.byte_idx)
                        2'h0: next_s.sensor_handle[7:0]  = req_data_i;
                        2'h1: next_s.sensor_handle[15:8] = req_data_i;
                        2'h2: next_s.rearm_mask          = req_data_i;
                        default: begin
                            // Reserved byte carries nothing
                            next_s.req_ready = 1'b0;
                            next_s.st        = S_CODE;
                        end
                    endcase
                end
            end
            S_CODE: begin
                if (rsp_free) begin
                    next_s.rsp_valid  = 1'b1;
                    next_s.out_is_rec = 1'b0;
                    if (handle_bad) begin
                        next_s.rsp_data = UNKNOWN_HANDLE_CODE;
                        next_s.rsp_last = 1'b1;
                        next_s.st       = S_DRAIN;
                    end else begin
                        next_s.rsp_data = SUCCESS_CODE;
                        next_s.count    = eff_count;
                        next_s.rearm    = s.rearm_mask & count_mask;
                        next_s.st       = S_COUNT;
                    end
                end
            end
            S_COUNT: begin
                if (rsp_free) begin
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data  = {4'h0, s.count};
                    next_s.rec_idx   = '0;
                    next_s.fld_idx   = '0;
                    next_s.st        = S_REC;
                end
            end
            S_REC: begin
                if (rsp_free) begin
                    next_s.rsp_valid  = 1'b1;
                    next_s.rsp_data   = rec_byte;
                    next_s.out_is_rec = 1'b1;
                    next_s.out_rec    = s.rec_idx;
                    next_s.out_fld    = s.fld_idx;
                    next_s.fld_idx    = s.fld_idx + 2'h1;
                    if (s.fld_idx == REC_LAST_FIELD) begin
                        next_s.rec_idx = s.rec_idx + 3'h1;
                        if ({1'b0, s.rec_idx} == s.count - 4'h1) begin
                            next_s.rsp_last = 1'b1;
                            next_s.st       = S_DRAIN;
                        end
                    end
                end
            end
            S_DRAIN: begin
                if (s.rsp_valid && rsp_ready_i) begin
                    next_s.st         = S_REQ;
                    next_s.byte_idx   = '0;
                    next_s.req_ready  = 1'b1;
                    next_s.out_is_rec = 1'b0;
                end
            end
            default: begin
                next_s.st = S_REQ;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s           <= '0;
            s.st        <= S_REQ;
            s.req_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign req_ready_o = s.req_ready;
    assign rsp_valid_o = s.rsp_valid;
    assign rsp_data_o  = s.rsp_data;
    assign rsp_last_o  = s.rsp_last;

    // Helper: record bytes accepted in the current response
    logic [5:0] rec_bytes_seen;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || s.st == S_REQ) begin
            rec_bytes_seen <= '0;
        end else if (s.rsp_valid && rsp_ready_i && s.out_is_rec) begin
            rec_bytes_seen <= rec_bytes_seen + 6'h1;
        end
    end

    property p_rearm_map;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.rearm & ~s.rearm_mask) == 8'h00;
    endproperty
    a_rearm_map: assert property (p_rearm_map)
        else $error("Re-arm pulse on a sub-sensor whose mask bit is clear");

    property p_rearm_good;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.st == S_CODE && rsp_free && !handle_bad)
            |=> s.rearm == ($past(s.rearm_mask) & $past(count_mask));
    endproperty
    a_rearm_good: assert property (p_rearm_good)
        else $error("Re-arm pulses do not follow the mask");

    property p_rearm_above;
        @(posedge core_clk_i) disable iff (rst_i)
        s.rearm != 8'h00 |-> (s.rearm >> s.count) == 8'h00;
    endproperty
    a_rearm_above: assert property (p_rearm_above)
        else $error("Mask bit at or above the count re-armed a sub-sensor");

    property p_bad_handle;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.st == S_CODE && rsp_free && handle_bad)
            |=> rsp_valid_o && rsp_last_o
                && rsp_data_o == UNKNOWN_HANDLE_CODE;
    endproperty
    a_bad_handle: assert property (p_bad_handle)
        else $error("Unknown handle not answered with a lone 0x80 code");

    property p_count_range;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.st == S_COUNT && rsp_free)
            |=> rsp_valid_o && rsp_data_o >= 8'h01 && rsp_data_o <= 8'h08;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("Sub-sensor count byte out of range");

    property p_rec_total;
        @(posedge core_clk_i) disable iff (rst_i)
        (rsp_valid_o && rsp_last_o && s.out_is_rec)
            |-> 8'(rec_bytes_seen) == 8'({s.count, 2'h0}) - 8'h01;
    endproperty
    a_rec_total: assert property (p_rec_total)
        else $error("Record byte total differs from four per sub-sensor");

    // Position follows the accepted byte count, so stalls cannot skew it
    property p_rec_order;
        @(posedge core_clk_i) disable iff (rst_i)
        (rsp_valid_o && s.out_is_rec)
            |-> s.out_fld == rec_bytes_seen[1:0]
                && s.out_rec == rec_bytes_seen[4:2];
    endproperty
    a_rec_order: assert property (p_rec_order)
        else $error("Record byte emitted out of its fixed position");

    property p_rec_step;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.st == S_REC && rsp_free && s.fld_idx == REC_LAST_FIELD
            && s.rsp_last == 1'b0 && {1'b0, s.rec_idx} != s.count - 4'h1)
            |=> s.fld_idx == 2'h0 && s.rec_idx == $past(s.rec_idx) + 3'h1
                && s.out_fld == REC_LAST_FIELD;
    endproperty
    a_rec_step: assert property (p_rec_step)
        else $error("Record fields not emitted in fixed order");

    property p_cur_field;
        @(posedge core_clk_i) disable iff (rst_i)
        (s.st == S_REC && rsp_free && s.fld_idx == 2'h1)
            |=> rsp_data_o == $past(cur_a[s.rec_idx]);
    endproperty
    a_cur_field: assert property (p_cur_field)
        else $error("Second record byte is not the current state");

    c_bad_handle: cover property (@(posedge core_clk_i) disable iff (rst_i)
        rsp_valid_o && rsp_data_o == UNKNOWN_HANDLE_CODE && !s.out_is_rec);
    c_eight_recs: cover property (@(posedge core_clk_i) disable iff (rst_i)
        rsp_last_o && s.out_is_rec && s.out_rec == 3'h7);
    c_rearm: cover property (@(posedge core_clk_i) disable iff (rst_i)
        s.rearm != 8'h00);
    c_stall: cover property (@(posedge core_clk_i) disable iff (rst_i)
        rsp_valid_o && !rsp_ready_i ##1 rsp_valid_o && rsp_ready_i);

endmodule

// [tb/mgmt_requester.sv]
// Partner model: the controller that issues sensor reading requests.
// Assumes the command block clock; tasks are called just after an edge.
`timescale 1ns/1ps
module mgmt_requester (
    input  wire logic       core_clk_i,
    input  wire logic       stall_i,
    input  wire logic       req_ready_i,
    output logic            req_valid_o,
    output logic [7:0]      req_data_o,
    output logic            rsp_ready_o
);
    initial begin
        req_valid_o = 1'b0;
        req_data_o  = 8'h00;
        rsp_ready_o = 1'b1;
    end

    // Sink may stall at random to exercise backpressure
    always @(posedge core_clk_i) begin
        rsp_ready_o <= stall_i ? 1'($urandom_range(1)) : 1'b1;
    end

    task automatic send(input logic [15:0] h, input logic [7:0] m);
        logic [7:0] b [4];
        b = '{h[7:0], h[15:8], m, 8'h00};
        for (int i = 0; i < 4; i++) begin
            req_valid_o <= 1'b1;
            req_data_o  <= b[i];
            do @(posedge core_clk_i); while (req_ready_i !== 1'b1);
        end
        req_valid_o <= 1'b0;
        // Released line shows the inverse, not a stale byte
        req_data_o  <= ~b[3];
    endtask
endmodule

// [tb/state_sensor_read_cmd_tb_top.sv]
// Self-checking bench for the state sensor reading command block.
// Assumes the block answers within a few hundred cycles per request.
`timescale 1ns/1ps
module state_sensor_read_cmd_tb_top;
    import sensor_cmd_pkg::*;

    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic        stall      = 1'b0;
    logic [15:0] own_handle = 16'h5a3c;
    logic [3:0]  sub_count  = 4'h1;
    logic [63:0] op_state   = 64'h0;
    logic [7:0]  assess_valid = 8'h00;
    logic [63:0] assess_state = 64'h0;
    logic        req_valid;
    logic [7:0]  req_data;
    logic        req_ready;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        rsp_last;
    logic        rsp_ready;
    logic [8:0]  exp_q [$];
    logic [7:0]  cur [8];
    logic [7:0]  pri [8];
    logic [7:0]  evt [8];
    bit          known [8];
    bit          armed [8];
    int          err_total = 0;
    int          n_checks  = 0;
    int          cyc       = 0;

    initial forever #2.5 core_clk_i = ~core_clk_i;

    state_sensor_read_cmd i_state_sensor_read_cmd (
        .core_clk_i     (core_clk_i),
        .rst_i          (rst_i),
        .own_handle_i   (own_handle),
        .sub_count_i    (sub_count),
        .op_state_i     (op_state),
        .assess_valid_i (assess_valid),
        .assess_state_i (assess_state),
        .req_valid_i    (req_valid),
        .req_data_i     (req_data),
        .req_ready_o    (req_ready),
        .rsp_valid_o    (rsp_valid),
        .rsp_data_o     (rsp_data),
        .rsp_last_o     (rsp_last),
        .rsp_ready_i    (rsp_ready)
    );

    mgmt_requester i_mgmt_requester (
        .core_clk_i  (core_clk_i),
        .stall_i     (stall),
        .req_ready_i (req_ready),
        .req_valid_o (req_valid),
        .req_data_o  (req_data),
        .rsp_ready_o (rsp_ready)
    );

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One assessed value per strobed slot; model mirrors slot history
    task automatic assess(input logic [7:0] m, input logic [63:0] v);
        logic [7:0] s;
        @(posedge core_clk_i);
        assess_valid <= m;
        assess_state <= v;
        @(posedge core_clk_i);
        assess_valid <= 8'h00;
        assess_state <= ~v;
        for (int n = 0; n < 8; n++) begin
            s = v[8*n +: 8];
            if (m[n] && (!known[n] || s != cur[n])) begin
                pri[n] = known[n] ? cur[n] : s;
                cur[n] = s;
                known[n] = 1'b1;
                if (armed[n]) begin
                    evt[n] = s;
                    armed[n] = 1'b0;
                end
            end
        end
    endtask

    // Notes the expected response, sends, waits for it to drain
    task automatic request(input logic [15:0] h, input logic [7:0] m);
        int c;
        int k;
        c = (sub_count == 0) ? 1 : (sub_count > 8) ? 8 : int'(sub_count);
        if (h == HANDLE_RSV_LOW || h == HANDLE_RSV_HIGH || h != own_handle)
            exp_q.push_back({1'b1, UNKNOWN_HANDLE_CODE});
        else begin
            for (int n = 0; n < c; n++)
                if (m[n]) armed[n] = 1'b1;
            exp_q.push_back({1'b0, SUCCESS_CODE});
            exp_q.push_back({1'b0, 8'(c)});
            for (int n = 0; n < c; n++) begin
                exp_q.push_back({1'b0, op_state[8*n +: 8]});
                exp_q.push_back({1'b0, cur[n]});
                exp_q.push_back({1'b0, pri[n]});
                exp_q.push_back({n == c - 1, evt[n]});
            end
        end
        i_mgmt_requester.send(h, m);
        for (k = 0; k < 300 && (exp_q.size() != 0 || rsp_valid !== 1'b0); k++)
            @(posedge core_clk_i);
        if (k == 300) begin
            // Response never drained: count it and close the run
            err_total++;
            report_and_stop();
        end
        @(posedge core_clk_i);
        check({8'h00, req_ready}, 9'h001);
    endtask

    always @(posedge core_clk_i) begin
        if (!rst_i && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check({rsp_last, rsp_data}, ~{rsp_last, rsp_data});
            else
                check({rsp_last, rsp_data}, exp_q.pop_front());
        end
    end

    // Generous ceiling; the whole run needs a few thousand cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        logic [63:0] v1;
        void'($urandom(32'h5288));
        for (int n = 0; n < 8; n++) begin
            cur[n] = STATE_RESET;
            pri[n] = STATE_RESET;
            evt[n] = STATE_RESET;
            known[n] = 1'b0;
            armed[n] = 1'b1;
        end
        op_state = {$urandom, $urandom};
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        check({6'h00, req_ready, rsp_valid, rsp_last}, 9'h004);
        request(own_handle, 8'h00);
        v1 = {$urandom, $urandom};
        sub_count <= 4'h8;
        assess(8'hFF, v1);
        request(own_handle, 8'h00);
        assess(8'hFF, ~v1);
        request(own_handle, 8'h00);
        // Mask bits above the count must not re-arm
        sub_count <= 4'h4;
        @(posedge core_clk_i);
        request(own_handle, 8'hFF);
        assess(8'hFF, v1 ^ 64'h0101_0101_0101_0101);
        sub_count <= 4'h8;
        @(posedge core_clk_i);
        request(own_handle, 8'h00);
        request(HANDLE_RSV_LOW, 8'h00);
        request(HANDLE_RSV_HIGH, 8'h00);
        request(own_handle ^ 16'h0100, 8'h00);
        stall <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            sub_count <= 4'($urandom_range(15));
            op_state  <= {$urandom, $urandom};
            assess(8'($urandom), {$urandom, $urandom});
            request(($urandom_range(3) == 0) ? 16'($urandom) : own_handle,
                    8'($urandom));
        end
        report_and_stop();
    end
endmodule
